// >>> src/mms_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          module management status block.
// Assumes: 100 MHz block clock.
// Notes:   Definitions only.
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
// ------------------------------------------------------------------
// Byte addresses of the management map
// ------------------------------------------------------------------
`define MMS_ADDR_STATUS 8'h02
`define MMS_ADDR_FLAG_LOS 8'h03
`define MMS_ADDR_FLAG_TXF 8'h04
`define MMS_ADDR_FLAG_MISC 8'h05
`define MMS_ADDR_RATESEL 8'h57
`define MMS_ADDR_PWRCTL 8'h5d
`define MMS_ADDR_MASK_LO 8'h64
`define MMS_ADDR_MASK_HI 8'h6a
`define MMS_MASK_BYTES 7
// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define MMS_BIT_DNR 0
`define MMS_BIT_PDOWN 1
`define MMS_MASK_RST 8'h00
`define MMS_RATESEL_RST 8'h00
// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define MMS_CLK_MHZ 100
`define MMS_T_INIT_MS 2000
`define MMS_T_RESET_US 2
`define MMS_INIT_CYC (`MMS_T_INIT_MS * 1000 * `MMS_CLK_MHZ)
`define MMS_RESET_CYC (`MMS_T_RESET_US * `MMS_CLK_MHZ)
`endif

// >>> src/mms_pkg.sv
// Purpose: Types of the module management status block.
// Assumes: Nothing beyond the defs header.
// Notes:   Flags and conditions share one layout.
package mms_pkg;
  // Flag and condition layout: other flags, transmit fault, receive loss.
  typedef struct packed {
    logic [7:0] misc;
    logic [3:0] txf;
    logic [3:0] los;
  } mms_flags_t;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_READY = 2'b10
  } mms_state_t;
endpackage

// >>> src/mms_ctrl.sv
// Purpose: Management control and status sequencing of a pluggable module.
// Assumes: Serial clock, data and sideband pins are asynchronous to mclk.
// Notes:   Host writes and clear-on-read take effect at the serial clock
//          fall that follows the stop condition.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "mms_defs.svh"

module mms_ctrl
  import mms_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `MMS_INIT_CYC
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic module_reset_n,
  input wire logic low_power_request_pin,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire mms_flags_t cond_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic module_interrupt_n,
  output logic low_power_mode,
  output logic [7:0] rate_select,
  output logic serial_ready
);
  localparam int RESET_CYC = `MMS_RESET_CYC;

  // Mask byte decode, used by the read path only; the write path compares each byte address.
  function automatic logic is_mask(input logic [7:0] a);
    is_mask = (a >= `MMS_ADDR_MASK_LO) && (a <= `MMS_ADDR_MASK_HI);
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] rstn_sync_r; // Reset pin, two stages.
  logic [1:0] lp_sync_r; // Low-power pin, two stages.
  logic [2:0] scl_sync_r; // Serial clock, two stages plus edge history.
  logic [2:0] sda_sync_r; // Serial data, two stages plus edge history.
  mms_flags_t cond_m_r; // Condition first stage, read only by the second.
  mms_flags_t cond_r; // Synchronised conditions.

  // Every pin passes two flops before anything looks at it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rstn_sync_r <= 2'h3;
      lp_sync_r <= 2'h0;
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      cond_m_r <= '0;
      cond_r <= '0;
    end
    else
    begin
      rstn_sync_r <= {rstn_sync_r[0], module_reset_n};
      lp_sync_r <= {lp_sync_r[0], low_power_request_pin};
      scl_sync_r <= {scl_sync_r[1:0], scl_pin};
      sda_sync_r <= {sda_sync_r[1:0], sda_pin};
      cond_m_r <= cond_pin;
      cond_r <= cond_m_r;
    end
  end

  logic rstn_s; // Synchronised reset pin.
  logic lp_s; // Synchronised low-power request.
  logic scl_fall; // Serial clock falling edge seen.
  logic stop_det; // Data rises while clock stays high.
  assign rstn_s = rstn_sync_r[1];
  assign lp_s = lp_sync_r[1];
  assign scl_fall = scl_sync_r[2] & ~scl_sync_r[1];
  assign stop_det = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];

  // ------------------------------------------------------------------
  // Commit point after each bus transaction
  // ------------------------------------------------------------------
  logic stop_seen_r; // A stop was seen and its following clock fall not yet.
  logic commit; // Pulse at the clock fall after a stop.
  assign commit = stop_seen_r & scl_fall;

  // The host may let the clock stand after a stop; we simply wait for it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stop_seen_r <= 1'b0;
    else if (stop_det)
      stop_seen_r <= 1'b1;
    else if (scl_fall)
      stop_seen_r <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Reset recognition and initialisation sequencer
  // ------------------------------------------------------------------
  logic [7:0] low_cnt_r; // Cycles the reset pin has been low, saturating.
  logic [31:0] init_cnt_r; // Cycles spent initialising.
  mms_state_t state_r;
  logic reset_hit; // Reset pin low for longer than the minimum pulse.
  assign reset_hit = ~rstn_s && (low_cnt_r == 8'(RESET_CYC));

  // Short glitches on the reset pin are filtered by the low counter.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      low_cnt_r <= 8'h00;
    else if (rstn_s)
      low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'(RESET_CYC))
      low_cnt_r <= low_cnt_r + 8'h01;
  end

  // Power-on enters initialisation; a recognised reset holds until the
  // pin rises, then initialisation runs again.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_INIT;
      init_cnt_r <= 32'h0;
    end
    else if (reset_hit)
    begin
      state_r <= ST_HOLD;
      init_cnt_r <= 32'h0;
    end
    else
    begin
      unique case (state_r)
        ST_HOLD:
        begin
          if (rstn_s)
            state_r <= ST_INIT;
        end
        ST_INIT:
        begin
          // Done after the full INIT_CYCLES count; the counter stops one below the bound.
          if (init_cnt_r >= INIT_CYCLES - 1)
            state_r <= ST_READY;
          else
            init_cnt_r <= init_cnt_r + 32'h1;
        end
        ST_READY:
        begin
          init_cnt_r <= 32'h0;
        end
        default:
        begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  logic ready; // Fully functional and serving the bus.
  assign ready = (state_r == ST_READY);
  assign serial_ready = ready;

  // ------------------------------------------------------------------
  // Host-writable registers: shadow copies and live copies
  // ------------------------------------------------------------------
  logic [7:0] mask_sh_r [`MMS_MASK_BYTES]; // Written by the host.
  logic [7:0] mask_r [`MMS_MASK_BYTES]; // In force.
  logic pd_sh_r; // Power-down bit as written.
  logic pd_r; // Power-down bit in force.
  logic [7:0] rs_sh_r; // Rate select as written.
  logic wr_ok; // Accepted write.
  assign wr_ok = reg_wr & ready;

  // Shadows let a multi-byte write land together at its commit point.
  genvar gi;
  generate
    for (gi = 0; gi < `MMS_MASK_BYTES; gi++)
    begin : g_mask
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          mask_sh_r[gi] <= `MMS_MASK_RST;
          mask_r[gi] <= `MMS_MASK_RST;
        end
        else
        begin
          if (wr_ok && reg_addr == `MMS_ADDR_MASK_LO + 8'(gi))
            mask_sh_r[gi] <= reg_wdata;
          if (commit)
            mask_r[gi] <= mask_sh_r[gi];
        end
      end
    end
  endgenerate

  // Power-down and rate select follow the same shadow scheme.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pd_sh_r <= 1'b0;
      pd_r <= 1'b0;
      rs_sh_r <= `MMS_RATESEL_RST;
      rate_select <= `MMS_RATESEL_RST;
    end
    else
    begin
      if (wr_ok && reg_addr == `MMS_ADDR_PWRCTL)
        pd_sh_r <= reg_wdata[`MMS_BIT_PDOWN];
      if (wr_ok && reg_addr == `MMS_ADDR_RATESEL)
        rs_sh_r <= reg_wdata;
      if (commit)
      begin
        pd_r <= pd_sh_r;
        rate_select <= rs_sh_r;
      end
    end
  end

  // Low power follows the pin three cycles after it changes, and the bit in force one cycle after it changes.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      low_power_mode <= 1'b0;
    else
      low_power_mode <= lp_s | pd_r;
  end

  // ------------------------------------------------------------------
  // Flags, clear-on-read and interrupt
  // ------------------------------------------------------------------
  mms_flags_t flags_r; // Latched flags.
  mms_flags_t clr_pend_r; // Flags read and waiting for the commit point.
  logic ready_evt_r; // Initialisation-complete event, latched.
  logic ready_clr_r; // Status byte read, waiting for commit.
  logic ready_q_r; // Delayed ready, for the rising edge.
  mms_flags_t rd_snap; // Flags returned by the current read.
  logic rd_ok; // Accepted read.
  assign rd_ok = reg_rd & ready;

  // Only the bits that were actually returned get cleared later.
  always_comb
  begin
    rd_snap = '0;
    if (rd_ok)
    begin
      if (reg_addr == `MMS_ADDR_FLAG_LOS)
        rd_snap.los = flags_r.los;
      if (reg_addr == `MMS_ADDR_FLAG_TXF)
        rd_snap.txf = flags_r.txf;
      if (reg_addr == `MMS_ADDR_FLAG_MISC)
        rd_snap.misc = flags_r.misc;
    end
  end

  // A condition present in the commit cycle keeps its flag: set wins.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= '0;
      clr_pend_r <= '0;
    end
    else
    begin
      flags_r <= (commit ? (flags_r & ~clr_pend_r) : flags_r) | cond_r;
      clr_pend_r <= (commit ? mms_flags_t'('0) : clr_pend_r) | rd_snap;
    end
  end

  // Finishing initialisation raises its own event, cleared by a status read.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ready_q_r <= 1'b0;
      ready_evt_r <= 1'b0;
      ready_clr_r <= 1'b0;
    end
    else
    begin
      ready_q_r <= ready;
      if (ready && !ready_q_r)
        ready_evt_r <= 1'b1;
      else if (commit && ready_clr_r)
        ready_evt_r <= 1'b0;
      if (commit)
        ready_clr_r <= rd_ok && reg_addr == `MMS_ADDR_STATUS;
      else if (rd_ok && reg_addr == `MMS_ADDR_STATUS)
        ready_clr_r <= 1'b1;
    end
  end

  mms_flags_t eff_mask; // Mask bits in flag layout.
  logic irq_pend; // Some unmasked cause is present.
  assign eff_mask = {mask_r[2], mask_r[1][3:0], mask_r[0][3:0]};
  assign irq_pend = (|(flags_r & ~eff_mask)) | ready_evt_r;

  // The output is a flop so the pin never glitches while flags settle.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      module_interrupt_n <= 1'b1;
    else
      module_interrupt_n <= ~irq_pend;
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  // Before the bus is ready reads answer zero, as if nothing were there.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (!rd_ok)
      reg_rdata <= 8'h00;
    else if (is_mask(reg_addr))
      reg_rdata <= mask_sh_r[3'(reg_addr - `MMS_ADDR_MASK_LO)];
    else
    begin
      unique case (reg_addr)
        `MMS_ADDR_STATUS: reg_rdata <= 8'h00;
        `MMS_ADDR_FLAG_LOS: reg_rdata <= {4'h0, flags_r.los};
        `MMS_ADDR_FLAG_TXF: reg_rdata <= {4'h0, flags_r.txf};
        `MMS_ADDR_FLAG_MISC: reg_rdata <= flags_r.misc;
        `MMS_ADDR_RATESEL: reg_rdata <= rs_sh_r;
        `MMS_ADDR_PWRCTL: reg_rdata <= {6'h00, pd_sh_r, 1'b0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  init_bound_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_INIT |-> init_cnt_r < INIT_CYCLES)
    else $error("init ran past its bound");
  reset_recog_a: assert property (@(posedge mclk) disable iff (rst)
    reset_hit |=> state_r == ST_HOLD && !serial_ready)
    else $error("long reset pulse not recognised");
  bus_closed_a: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && !serial_ready |=> reg_rdata == 8'h00)
    else $error("read answered before ready");
  ready_irq_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ready) |=> ##1 !module_interrupt_n)
    else $error("no interrupt at end of init");
  lp_enter_a: assert property (@(posedge mclk) disable iff (rst)
    lp_s |=> low_power_mode)
    else $error("low power not entered");
  lp_exit_a: assert property (@(posedge mclk) disable iff (rst)
    !lp_s && !pd_r |=> !low_power_mode)
    else $error("low power not left");
  irq_set_a: assert property (@(posedge mclk) disable iff (rst)
    (|(cond_r & ~eff_mask)) && !commit |=> ##1 !module_interrupt_n)
    else $error("interrupt not asserted");
  irq_rel_a: assert property (@(posedge mclk) disable iff (rst)
    commit && ((flags_r & ~clr_pend_r) == '0) && (cond_r == '0) &&
    (!ready_evt_r || ready_clr_r) && !(ready && !ready_q_r) |=> ##1 module_interrupt_n)
    else $error("interrupt not released");
  los_flag_a: assert property (@(posedge mclk) disable iff (rst)
    |cond_r.los |=> (flags_r.los & $past(cond_r.los)) == $past(cond_r.los))
    else $error("loss flag not set");
  txf_flag_a: assert property (@(posedge mclk) disable iff (rst)
    |cond_r.txf |=> (flags_r.txf & $past(cond_r.txf)) == $past(cond_r.txf))
    else $error("fault flag not set");
  mask_load_a: assert property (@(posedge mclk) disable iff (rst)
    commit |=> mask_r[0] == $past(mask_sh_r[0]) && pd_r == $past(pd_sh_r))
    else $error("write not applied at commit");
  flag_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !commit |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag dropped without a read");
endmodule // mms_ctrl

// >>> tb/mms_host_model.sv
// Purpose: Host end of the management serial bus, cut down to what
//          the block uses: a stop followed by the next serial clock fall.
// Assumes: Both bus lines have pull-ups, so the idle level is high.
// Notes:   The serial clock only moves inside a frame tail.
`timescale 1ns/10ps

module mms_host_model (
  input wire logic mclk,
  input wire logic go,
  output logic scl_pin,
  output logic sda_pin,
  output logic done
);
  // ------------------------------------------------------------------
  // Frame tail generator
  // ------------------------------------------------------------------
  // Half of the 160 ns serial clock period, counted in mclk cycles.
  localparam int HALF = 8;

  // Lines idle high through the pull-ups until the first request.
  initial
  begin
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    done = 1'b0;
  end

  // Each request ends a transaction with a stop, then begins the next
  // one with a start, so the falling clock edge after the stop exists.
  // The request is a level, held by the bench until done, so a request
  // made while a tail is still running is picked up once it ends.
  always
  begin
    @(posedge mclk);
    while (go !== 1'b1)
      @(posedge mclk);
    scl_pin <= 1'b0;
    repeat (HALF) @(posedge mclk);
    sda_pin <= 1'b0;
    repeat (HALF) @(posedge mclk);
    scl_pin <= 1'b1;
    repeat (HALF) @(posedge mclk);
    sda_pin <= 1'b1;
    repeat (HALF) @(posedge mclk);
    sda_pin <= 1'b0;
    repeat (HALF) @(posedge mclk);
    scl_pin <= 1'b0;
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    // Data is raised while the clock is low, so no stray stop is made.
    repeat (HALF) @(posedge mclk);
    sda_pin <= 1'b1;
    repeat (HALF) @(posedge mclk);
    scl_pin <= 1'b1;
  end
endmodule // mms_host_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of the management status block.
// Assumes: Short init count through the parameter.
// Notes:   Register effects are applied by the host model's commit fall.
`timescale 1ns/10ps

module tb_top;
  import mms_pkg::*;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  // Short init count so that the run stays brief.
  localparam int INIT = 50;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_request_pin = 1'b0;
  logic go = 1'b0;
  mms_flags_t cond_pin = '0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic module_interrupt_n;
  logic low_power_mode;
  logic [7:0] rate_select;
  logic serial_ready;
  logic scl_pin;
  logic sda_pin;
  logic done;
  int err_count = 0;
  int check_count = 0;
  // Flag addresses, condition patterns and expected flag bytes.
  logic [7:0] ca [3] = '{8'h03, 8'h04, 8'h05};
  logic [15:0] cv [3] = '{16'h0002, 16'h0040, 16'h8000};
  logic [7:0] ev [3] = '{8'h02, 8'h04, 8'h80};

  mms_ctrl #(.INIT_CYCLES(INIT)) dut (.mclk, .rst, .module_reset_n, .low_power_request_pin,
    .scl_pin, .sda_pin, .cond_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .module_interrupt_n, .low_power_mode, .rate_select, .serial_ready);
  mms_host_model host (.mclk, .go, .scl_pin, .sda_pin, .done);

  // The block clock toggles every 5 ns for 100 MHz.
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task summarize;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compares one value, counting it and reporting a mismatch.
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      err_count++;
    end
  endtask

  // One-cycle write strobe.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Gives up the run when a bounded wait runs out.
  task give_up(input string s);
    $display("wrong value at %0t: %s never came", $time, s);
    err_count++;
    summarize;
  endtask

  // Ends a transaction so that pending writes and reads take effect.
  // The request stands until the model's done is sampled high.
  task cmt;
    @(posedge mclk);
    go <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge mclk);
      if (done === 1'b1)
      begin
        go <= 1'b0;
        return;
      end
    end
    give_up("commit");
  endtask

  // Waits at most n cycles for interrupt (0), ready (1) or low power (2).
  task wt(input int s, input logic e, input int n);
    logic v;
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      #1;
      v = (s == 0) ? module_interrupt_n : (s == 1) ? serial_ready : low_power_mode;
      if (v === e)
      begin
        check_count++;
        return;
      end
    end
    give_up("output level");
  endtask

  // Raises a condition for a few cycles, then takes it away again.
  task pulse(input logic [15:0] v);
    @(posedge mclk);
    cond_pin <= v;
    repeat (5) @(posedge mclk);
    cond_pin <= '0;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    chk(module_interrupt_n, 1'b1);
    chk(serial_ready, 1'b0);
    rst <= 1'b0;
    // Access before ready must be dropped and read as zero.
    wr(8'h57, 8'hff);
    rd(8'h57, 8'h00);
    wt(1, 1'b1, INIT + 20);
    wt(0, 1'b0, 5);
    rd(8'h02, 8'h00);
    rd(8'h57, 8'h00);
    cmt;
    wt(0, 1'b1, 12);
    // Each flag group latches, interrupts, and clears on a committed read.
    for (int k = 0; k < 3; k++)
    begin
      pulse(cv[k]);
      wt(0, 1'b0, 20);
      rd(ca[k], ev[k]);
      chk(module_interrupt_n, 1'b0);
      cmt;
      wt(0, 1'b1, 12);
      rd(ca[k], 8'h00);
    end
    // Mask bytes hold their value; the unmapped address reads zero.
    wr(8'h64, 8'h01);
    rd(8'h64, 8'h01);
    wr(8'h6a, 8'h5a);
    rd(8'h6a, 8'h5a);
    rd(8'h7f, 8'h00);
    cmt;
    pulse(16'h0001);
    repeat (20) @(posedge mclk);
    #1 chk(module_interrupt_n, 1'b1);
    rd(8'h03, 8'h01);
    cmt;
    wr(8'h64, 8'h00);
    cmt;
    pulse(16'h0001);
    wt(0, 1'b0, 20);
    rd(8'h03, 8'h01);
    cmt;
    wt(0, 1'b1, 12);
    // The fault and other-flag masks silence their groups as well.
    wr(8'h65, 8'h0f);
    wr(8'h66, 8'hff);
    cmt;
    pulse(16'hfff0);
    repeat (20) @(posedge mclk);
    #1 chk(module_interrupt_n, 1'b1);
    rd(8'h04, 8'h0f);
    rd(8'h05, 8'hff);
    wr(8'h65, 8'h00);
    wr(8'h66, 8'h00);
    cmt;
    repeat (4) @(posedge mclk);
    #1 chk(module_interrupt_n, 1'b1);
    // Rate select waits for the commit fall, then settles at once.
    wr(8'h57, 8'ha5);
    repeat (4) @(posedge mclk);
    #1 chk(rate_select, 8'h00);
    cmt;
    repeat (8) @(posedge mclk);
    #1 chk(rate_select, 8'ha5);
    // Power-down bit, then the low-power pin.
    wr(8'h5d, 8'h02);
    repeat (4) @(posedge mclk);
    #1 chk(low_power_mode, 1'b0);
    cmt;
    wt(2, 1'b1, 10);
    wr(8'h5d, 8'h00);
    cmt;
    wt(2, 1'b0, 10);
    @(posedge mclk);
    low_power_request_pin <= 1'b1;
    wt(2, 1'b1, 10);
    @(posedge mclk);
    low_power_request_pin <= 1'b0;
    wt(2, 1'b0, 10);
    // A short reset pulse is ignored; a long one restarts the init.
    @(posedge mclk);
    module_reset_n <= 1'b0;
    repeat (150) @(posedge mclk);
    module_reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(serial_ready, 1'b1);
    @(posedge mclk);
    module_reset_n <= 1'b0;
    repeat (300) @(posedge mclk);
    #1 chk(serial_ready, 1'b0);
    @(posedge mclk);
    module_reset_n <= 1'b1;
    wt(1, 1'b1, INIT + 20);
    wt(0, 1'b0, 5);
    rd(8'h02, 8'h00);
    cmt;
    wt(0, 1'b1, 12);
    summarize;
  end
endmodule // tb_top
